/* rtl/lpr_pkg.sv */
// Shared constants and types for the LED PWM, ramp and blink driver
package lpr_pkg;
   // ==========================================================
   // Register map and layout
   localparam int ADDR_W = 9;
   localparam logic [8:0] A_CTRL_A = 9'h025;
   localparam logic [8:0] A_SIGNAL_LED_CTRL_B = 9'h026;
   localparam logic [8:0] A_CTRL_C = 9'h027;
   localparam logic [8:0] A_CAMERA_STRING_CTRL = 9'h02b;
   localparam logic [8:0] A_DUTY0 = 9'h02c;
   localparam logic [8:0] A_BKLT_EXT = 9'h1d3;
   localparam logic [8:0] A_BKLT4_DUTY = 9'h1d4;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_BKLT_EXT = 8'h07;
   localparam int CAM_EN_BIT = 0;
   localparam int CAM_DUTY_LSB = 1;
   localparam int CAM_DUTY_W = 3;
   localparam int CAM_STORE_W = 4;
   localparam int BKLT4_BIT = 3;
   localparam int CUR_W = 2;
   localparam int BLINK_LSB = 2;
   localparam int CH_FIELD_W = 4;
   localparam int DUTY_W = 6;
   localparam int RAMP_BIT = 6;
   localparam int BUSY_BIT = 7;
   // ==========================================================
   // Channels and timing, in 32 kHz ticks or in seconds
   localparam int NCH = 6;
   localparam int GCNT_W = 18;
   localparam int TICK_HZ = 32768;
   localparam int PWM_STEPS = 32;
   localparam int RAMP_STEPS_PER_S = 64;
   localparam int RAMP_STEP_TICKS = TICK_HZ / RAMP_STEPS_PER_S;
   localparam int STEP_SHIFT = $clog2(RAMP_STEP_TICKS);
   localparam logic [17:0] STEP_MASK = 18'(RAMP_STEP_TICKS - 1);
   localparam logic [17:0] PWM_MASK = 18'(PWM_STEPS - 1);
   localparam logic [5:0] DEF_ON_STEPS = 6'h20;
   localparam int BLINK1_S = 1;
   localparam int BLINK2_S = 4;
   localparam int BLINK3_S = 8;
   localparam logic [17:0] BLINK1_MASK = 18'(TICK_HZ * BLINK1_S - 1);
   localparam logic [17:0] BLINK2_MASK = 18'(TICK_HZ * BLINK2_S - 1);
   localparam logic [17:0] BLINK3_MASK = 18'(TICK_HZ * BLINK3_S - 1);
   localparam int CAM_CNT_W = 8;
   localparam logic [7:0] CAM_CNT_MAX = 8'hff;

   typedef enum logic [2:0] {
      LPR_CAM_OFF = 3'b001,
      LPR_CAM_SCENE = 3'b010,
      LPR_CAM_BKLT = 3'b100
   } lpr_cam_mode_t;
endpackage

/* rtl/lpr_cam_if.sv */
// Signals between the channel core and the camera string driver
`timescale 1ns/1ns
interface lpr_cam_if;
   logic tick;
   logic enable;
   logic [2:0] duty_code;
   logic bklt_mode;
   logic [7:0] bklt_duty;
   logic sink;
   modport ctrl (output tick, enable, duty_code, bklt_mode, bklt_duty,
      input sink);
   modport drv (input tick, enable, duty_code, bklt_mode, bklt_duty,
      output sink);
endinterface

/* rtl/lpr_cam_pwm.sv */
// Camera string PWM driver with fixed period and 3-bit duty
`timescale 1ns/1ns
module lpr_cam_pwm (
   input wire logic clk, // 10 MHz clock
   input wire logic rst_b, // Asynchronous reset
   input wire logic ce, // Clock enable
   lpr_cam_if.drv cam // Settings in, sink level out
);
   typedef struct packed {
      lpr_pkg::lpr_cam_mode_t mode;
      logic [7:0] cnt;
      logic sink;
   } lpr_cam_st_t;

   lpr_cam_st_t q;
   lpr_cam_st_t d;

   // ==========================================================
   // Next state
   always_comb
   begin
      d = q;
      if (cam.bklt_mode)
         d.mode = lpr_pkg::LPR_CAM_BKLT;
      else if (cam.enable)
         d.mode = lpr_pkg::LPR_CAM_SCENE;
      else
         d.mode = lpr_pkg::LPR_CAM_OFF;
      if (cam.tick)
         d.cnt = q.cnt + 8'h01;
      case (d.mode)
         lpr_pkg::LPR_CAM_OFF: d.sink = 1'b0;
         lpr_pkg::LPR_CAM_SCENE:
            d.sink = (q.cnt[7:5] <= cam.duty_code);
         lpr_pkg::LPR_CAM_BKLT: d.sink = (q.cnt < cam.bklt_duty);
         default: d.sink = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '{mode: lpr_pkg::LPR_CAM_OFF, cnt: 8'h00, sink: 1'b0};
      else if (ce)
         q <= d;
   end

   assign cam.sink = q.sink;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_cam_off: assert property (
      ce && !cam.enable && !cam.bklt_mode |=> !cam.sink)
      else $error("camera string on while disabled");
   a_cam_full: assert property (
      ce && cam.enable && !cam.bklt_mode && cam.duty_code == 3'h7
      |=> cam.sink)
      else $error("camera string off at full duty");
   a_cam_wrap: assert property (
      ce && cam.tick && q.cnt == lpr_pkg::CAM_CNT_MAX |=> q.cnt == 8'h00)
      else $error("camera period not fixed");
   a_cam_bklt: assert property (
      ce && cam.bklt_mode && cam.bklt_duty == 8'h00 |=> !cam.sink)
      else $error("camera string ignores backlight duty");
endmodule // lpr_cam_pwm

/* rtl/lpr_top.sv */
// Signal LED channels with PWM, ramp and blink, plus camera string
// Behaviour
// - Camera string on only while enable set or reassigned to backlight
// - Camera duty is (code+1) eighths
// - Camera PWM period fixed, duty varies
// - Reassigned camera string follows backlight duty
// - Extended backlight bit 3 allows reassignment
// - Six independent signal channels
// - Two-bit current code per channel
// - Six-bit duty in thirty-second steps
// - Channels staggered by one 32 kHz tick
// - Ramp one step every 1/64 s
// - Each duty change retargets the ramp from the applied level
// - Without ramp, duty applies at once
// - Blink code sets 1, 4, 8 s period
// - Blink on time follows duty, default 0.5 s
// - No ramping while blinking
// - Outputs usable as open-drain or PWM
`timescale 1ns/1ns
module lpr_top (
   input wire logic clk, // 10 MHz clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state
   input wire logic clk32k_pin, // 32 kHz timebase pin
   input wire logic [8:0] reg_addr, // Register address
   input wire logic reg_wr, // Register write strobe
   input wire logic [7:0] reg_wdata, // Register write data
   output logic [7:0] reg_rdata, // Registered read data
   output logic [5:0] ch_sink_on, // Channel sink active
   output logic [11:0] ch_current, // Channel current codes
   output logic cam_sink_on // Camera string sink active
);
   typedef struct packed {
      logic [2:0] sync;
      logic [17:0] gcnt;
      logic [2:0][7:0] cb;
      logic [3:0] cam_ctrl;
      logic [7:0] bklt_ext;
      logic [7:0] bklt4;
      logic [5:0][6:0] duty;
      logic [5:0][5:0] applied;
      logic [5:0] sink;
      logic [7:0] rdata;
   } lpr_st_t;

   lpr_st_t q;
   lpr_st_t d;
   logic tick;
   logic step;
   logic [5:0][1:0] blink;
   lpr_cam_if cam_bus ();

   // ==========================================================
   // Timebase
   // ticks from the 32 kHz pin
   assign tick = q.sync[1] & ~q.sync[2];
   assign step = tick && ((q.gcnt & lpr_pkg::STEP_MASK) == 18'h00000);

   // ==========================================================
   // Field views
   always_comb
   begin
      for (int i = 0; i < lpr_pkg::NCH; i++)
      begin
         blink[i] = q.cb[i / 2][(i % 2) * lpr_pkg::CH_FIELD_W
            + lpr_pkg::BLINK_LSB +: 2];
      end
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      logic [5:0] set;
      logic [5:0] on_steps;
      logic [4:0] ph;
      logic [17:0] bph;
      logic [17:0] mask;
      logic [8:0] di;
      set = 6'h00;
      on_steps = 6'h00;
      ph = 5'h00;
      bph = 18'h00000;
      mask = 18'h00000;
      di = 9'h000;
      d = q;
      d.sync = {q.sync[1], q.sync[0], clk32k_pin};
      if (tick)
         d.gcnt = q.gcnt + 18'h00001;

      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            lpr_pkg::A_CTRL_A: d.cb[0] = reg_wdata;
            lpr_pkg::A_SIGNAL_LED_CTRL_B: d.cb[1] = reg_wdata;
            lpr_pkg::A_CTRL_C: d.cb[2] = reg_wdata;
            lpr_pkg::A_CAMERA_STRING_CTRL:
               d.cam_ctrl = reg_wdata[lpr_pkg::CAM_STORE_W-1:0];
            lpr_pkg::A_BKLT_EXT: d.bklt_ext = reg_wdata;
            lpr_pkg::A_BKLT4_DUTY: d.bklt4 = reg_wdata;
            default:
            begin
               di = reg_addr - lpr_pkg::A_DUTY0;
               if (reg_addr >= lpr_pkg::A_DUTY0 &&
                  di < 9'(lpr_pkg::NCH))
                  d.duty[di[2:0]] = reg_wdata[6:0];
            end
         endcase
      end

      // each channel on its own settings
      for (int i = 0; i < lpr_pkg::NCH; i++)
      begin
         set = q.duty[i][lpr_pkg::DUTY_W-1:0];
         if (blink[i] != 2'h0 || !q.duty[i][lpr_pkg::RAMP_BIT])
            d.applied[i] = set;
         else if (step && q.applied[i] < set)
            d.applied[i] = q.applied[i] + 6'h01;
         else if (step && q.applied[i] > set)
            d.applied[i] = q.applied[i] - 6'h01;

         ph = 5'((q.gcnt - 18'(i)) & lpr_pkg::PWM_MASK);
         case (blink[i])
            2'h1: mask = lpr_pkg::BLINK1_MASK;
            2'h2: mask = lpr_pkg::BLINK2_MASK;
            2'h3: mask = lpr_pkg::BLINK3_MASK;
            default: mask = 18'h00000;
         endcase
         bph = (q.gcnt - 18'(i)) & mask;
         // on time in 1/64 s steps
         on_steps = (q.applied[i] == 6'h00) ? lpr_pkg::DEF_ON_STEPS
            : q.applied[i];
         if (tick)
         begin
            if (blink[i] != 2'h0)
               d.sink[i] = bph < (18'(on_steps) << lpr_pkg::STEP_SHIFT);
            else
               d.sink[i] = {1'b0, ph} < q.applied[i];
         end
      end

      // Read data, unmapped and reserved bits read zero
      case (reg_addr)
         lpr_pkg::A_CTRL_A: d.rdata = q.cb[0];
         lpr_pkg::A_SIGNAL_LED_CTRL_B: d.rdata = q.cb[1];
         lpr_pkg::A_CTRL_C: d.rdata = q.cb[2];
         lpr_pkg::A_CAMERA_STRING_CTRL: d.rdata = {4'h0, q.cam_ctrl};
         lpr_pkg::A_BKLT_EXT: d.rdata = q.bklt_ext;
         lpr_pkg::A_BKLT4_DUTY: d.rdata = q.bklt4;
         default:
         begin
            d.rdata = 8'h00;
            di = reg_addr - lpr_pkg::A_DUTY0;
            if (reg_addr >= lpr_pkg::A_DUTY0 && di < 9'(lpr_pkg::NCH))
               d.rdata = {q.applied[di[2:0]] !=
                  q.duty[di[2:0]][lpr_pkg::DUTY_W-1:0],
                  q.duty[di[2:0]]};
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
         q.bklt_ext <= lpr_pkg::RST_BKLT_EXT;
      end
      else if (ce)
         q <= d;
   end

   // ==========================================================
   // Camera string
   // enable bit to driver
   assign cam_bus.enable = q.cam_ctrl[lpr_pkg::CAM_EN_BIT];
   assign cam_bus.duty_code =
      q.cam_ctrl[lpr_pkg::CAM_DUTY_LSB +: lpr_pkg::CAM_DUTY_W];
   assign cam_bus.bklt_mode = q.bklt_ext[lpr_pkg::BKLT4_BIT];
   assign cam_bus.bklt_duty = q.bklt4;
   assign cam_bus.tick = tick;

   lpr_cam_pwm u_cam (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .cam(cam_bus.drv)
   );

   // ==========================================================
   // Outputs
   // sink level serves LED, open drain or PWM
   assign ch_sink_on = q.sink;
   assign cam_sink_on = cam_bus.sink;
   assign reg_rdata = q.rdata;
   always_comb
   begin
      for (int i = 0; i < lpr_pkg::NCH; i++)
      begin
         ch_current[i*2 +: 2] =
            q.cb[i / 2][(i % 2) * lpr_pkg::CH_FIELD_W +: lpr_pkg::CUR_W];
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_bklt_select: assert property (
      ce && reg_wr && reg_addr == lpr_pkg::A_BKLT_EXT
      |=> cam_bus.bklt_mode == $past(reg_wdata[3]))
      else $error("camera reassignment bit not applied");
   a_current_write: assert property (
      ce && reg_wr && reg_addr == lpr_pkg::A_SIGNAL_LED_CTRL_B
      |=> ch_current[5:4] == $past(reg_wdata[1:0])
         && ch_current[7:6] == $past(reg_wdata[5:4]))
      else $error("current code not taken");
   a_step_rate: assert property (
      step |-> q.gcnt[8:0] == 9'h000 && tick)
      else $error("ramp step off its divider");

   for (genvar g = 0; g < lpr_pkg::NCH; g++)
   begin : g_chk
      a_ramp_up: assert property (
         ce && step && blink[g] == 2'h0 && q.duty[g][6]
         && q.applied[g] < q.duty[g][5:0]
         |=> q.applied[g] == $past(q.applied[g]) + 6'h01)
         else $error("ramp did not step up");
      a_ramp_hold: assert property (
         ce && !step && blink[g] == 2'h0 && q.duty[g][6]
         |=> $stable(q.applied[g]))
         else $error("ramp moved between steps");
      a_duty_direct: assert property (
         ce && !q.duty[g][6] |=> q.applied[g] == $past(q.duty[g][5:0]))
         else $error("unramped duty not immediate");
      a_blink_noramp: assert property (
         ce && blink[g] != 2'h0
         |=> q.applied[g] == $past(q.duty[g][5:0]))
         else $error("ramp active while blinking");
      a_pwm_full: assert property (
         ce && tick && blink[g] == 2'h0 && q.applied[g] >= 6'h20
         |=> ch_sink_on[g])
         else $error("full duty channel off");
      a_pwm_zero: assert property (
         ce && tick && blink[g] == 2'h0 && q.applied[g] == 6'h00
         |=> !ch_sink_on[g])
         else $error("zero duty channel on");
      a_blink_off: assert property (
         ce && tick && blink[g] == 2'h1 && q.applied[g] == 6'h00
         && ((q.gcnt - 18'(g)) & lpr_pkg::BLINK1_MASK) >= 18'h04000
         |=> !ch_sink_on[g])
         else $error("blink on past default on time");
   end
endmodule // lpr_top

/* dv/lpr_led_model.sv */
// Behavioural model of the LEDs hanging on the sink outputs
`timescale 1ns/1ns
module lpr_led_model (
   input wire logic clk, // Sampling clock
   input wire logic [6:0] sink, // Sinks on, camera string is bit 6
   output logic [6:0] pin_level // Pin level with a pull-up fitted
);
   int on_cnt [7] = '{default: 0};
   time rise_t [7] = '{default: 0};
   logic [6:0] prev = 7'h00;
   assign pin_level = ~sink;
   always @(posedge clk)
   begin
      prev <= sink;
      for (int i = 0; i < 7; i++)
      begin
         if (sink[i] === 1'b1)
         begin
            on_cnt[i] <= on_cnt[i] + 1;
            if (prev[i] !== 1'b1)
            begin
               rise_t[i] <= $time;
            end
         end
      end
   end
endmodule // lpr_led_model

/* dv/testbench.sv */
// Self-checking bench for the LED PWM, ramp and blink driver
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk32k_pin = 1'b0;
   logic [8:0] reg_addr = 9'h000;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [5:0] ch_sink_on;
   logic [11:0] ch_current;
   logic cam_sink_on;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   int d;

   lpr_top dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
      .clk32k_pin(clk32k_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ch_sink_on(ch_sink_on), .ch_current(ch_current),
      .cam_sink_on(cam_sink_on));
   lpr_led_model m (.clk(clk), .sink({cam_sink_on, ch_sink_on}),
      .pin_level());

   // ==========================================================
   // Clocks and timeout
   initial
   begin
      forever #50 clk = ~clk;
   end
   // Timebase pin sped up to 8 clocks a tick to keep the run short
   initial
   begin
      #137;
      forever #400 clk32k_pin = ~clk32k_pin;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         n_errors++;
         $display("[ERR] %0t run timed out", $time);
         report_and_stop();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      total_checks++;
      if (got != exp)
      begin
         n_errors++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge clk);
      #10 reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk);
      #10 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge clk);
      #10 reg_addr = a;
      @(posedge clk);
      #1 v = reg_rdata;
   endtask
   task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk8(v, exp);
   endtask
   task automatic meas(input int i, input int ncyc, input int exp);
      int a;
      repeat (16) @(posedge clk);
      a = m.on_cnt[i];
      repeat (ncyc) @(posedge clk);
      chkn(m.on_cnt[i] - a, exp);
   endtask
   task automatic wait_idle(input logic [8:0] a, output int t);
      logic [7:0] v;
      t = 0;
      do
      begin
         rd(a, v);
         t += 2;
      end
      while (v[7] !== 1'b0 && t < 20000);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rdchk(9'h026, 8'h00);
      rdchk(9'h02b, 8'h00);
      rdchk(9'h1d3, 8'h07);
      wr(9'h1ff, 8'hff);
      rdchk(9'h1ff, 8'h00);
      $display("done reset");
   endtask
   task automatic t_current();
      for (int c = 0; c < 4; c++)
      begin
         wr(9'h026, {2'b00, 2'(c), 2'b00, 2'(c)});
         chk8({6'h00, ch_current[5:4]}, 8'(c));
         chk8({6'h00, ch_current[7:6]}, 8'(c));
         chk8({4'h0, ch_current[3:0]}, 8'h00);
      end
      wr(9'h026, 8'h00);
      $display("done current");
   endtask
   task automatic t_duty();
      for (int i = 0; i < 6; i++)
      begin
         wr(9'h02c + 9'(i), 8'h08);
      end
      repeat (300) @(posedge clk);
      for (int i = 0; i < 6; i++)
      begin
         d = int'(m.rise_t[i]) - int'(m.rise_t[0]);
         chkn((d + 25600) % 25600, i * 800);
         meas(i, 256, 64);
      end
      wr(9'h02c, 8'h00);
      meas(0, 256, 0);
      wr(9'h02c, 8'h20);
      meas(0, 256, 256);
      for (int i = 0; i < 6; i++)
      begin
         wr(9'h02c + 9'(i), 8'h00);
      end
      $display("done duty");
   endtask
   task automatic t_ramp();
      wr(9'h02c, 8'h42);
      rdchk(9'h02c, 8'hc2);
      wait_idle(9'h02c, n);
      chkn(int'(n > 4096 && n <= 8200), 1);
      meas(0, 256, 16);
      wr(9'h02c, 8'h45);
      repeat (300) @(posedge clk);
      wr(9'h02c, 8'h40);
      rdchk(9'h02c, 8'hc0);
      wait_idle(9'h02c, n);
      chkn(int'(n < 20000), 1);
      meas(0, 256, 0);
      wr(9'h02c, 8'h00);
      $display("done ramp");
   endtask
   task automatic t_blink();
      wr(9'h026, 8'h04);
      wr(9'h02e, 8'h48);
      rdchk(9'h02e, 8'h48);
      wr(9'h026, 8'h00);
      wr(9'h02e, 8'h00);
      $display("done blink");
   endtask
   task automatic t_camera();
      wr(9'h02b, 8'hff);
      rdchk(9'h02b, 8'h0f);
      for (int c = 0; c < 8; c++)
      begin
         wr(9'h02b, {4'h0, 3'(c), 1'b1});
         meas(6, 2048, (c + 1) * 256);
      end
      wr(9'h02b, 8'h0e);
      meas(6, 2048, 0);
      wr(9'h1d4, 8'h40);
      wr(9'h1d3, 8'h0f);
      meas(6, 2048, 512);
      wr(9'h1d3, 8'h07);
      meas(6, 2048, 0);
      $display("done camera");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      #10 rst_b = 1'b1;
      t_reset();
      t_current();
      t_duty();
      t_ramp();
      t_blink();
      t_camera();
      report_and_stop();
   end
endmodule // testbench
